/* hw/tsq_setup_seq.sv */
// Our own choices: the AHB-Lite slave port and the placing of the registers.
module tsq_setup_seq (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic tri_valid_o,
    input wire logic tri_ready_i,
    output logic [tsq_pkg::TSQ_NF-1:0][31:0] tri_vtx0_o,
    output logic [tsq_pkg::TSQ_NF-1:0][31:0] tri_vtx1_o,
    output logic [tsq_pkg::TSQ_NF-1:0][31:0] tri_vtx2_o,
    output logic [7:0] tri_param_sel_o,
    output logic tri_neg_sign_o,
    output logic [31:0] pbu_global_inv_w_o,
    output logic [31:0] tex_global_inv_w_o
);
    import tsq_pkg::*;

    logic dp_valid;
    logic dp_write;
    logic [5:0] dp_idx;
    logic addr_take;
    logic wr_fire;
    logic [31:0] setup_param_mode;
    logic [TSQ_NF-1:0][31:0] cur;
    logic [TSQ_NF-1:0][31:0] held;
    logic [TSQ_NF-1:0][31:0] slot0;
    logic [TSQ_NF-1:0][31:0] slot1;
    logic [TSQ_NF-1:0][31:0] next_vtx;
    logic [1:0] vcnt;
    logic parity;
    logic [TSQ_CNT_W-1:0] triangle_count;
    logic do_begin;
    logic do_draw;
    logic make_tri;
    logic area_neg;
    logic neg_eff;
    logic cull;
    logic [31:0] rd_mux;

    // Per-field enable mask from the parameter-select bits
    function automatic logic [31:0] field_en(input logic [31:0] m, input int f);
        logic [31:0] en;
        en = 32'h0000_0000;
        unique case (f)
            F_X, F_Y: en = 32'hFFFF_FFFF;
            F_ARGB: en = {{8{m[MB_ALPHA]}}, {24{m[MB_RGB]}}};
            F_Z: en = {32{m[MB_Z]}};
            F_GINVW: en = {32{m[MB_GINVW]}};
            F_TEX0_INVW: en = {32{m[MB_TEX0_INVW]}};
            F_TEX0_S, F_TEX0_T: en = {32{m[MB_ST0]}};
            F_TEX1_INVW: en = {32{m[MB_TEX1_INVW]}};
            F_TEX1_S, F_TEX1_T: en = {32{m[MB_ST1]}};
            default: en = 32'h0000_0000;
        endcase
        return en;
    endfunction

    function automatic logic is_field(input logic [5:0] idx);
        return (idx >= IDX_FIELD0) && (idx < IDX_FIELD0 + 6'(TSQ_NF));
    endfunction

    // Bus slave: address phase capture
    assign addr_take = hsel_i && hready_i && htrans_i[1];

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_idx <= 6'h00;
        end else if (hready_i) begin
            dp_valid <= addr_take;
            dp_write <= hwrite_i;
            dp_idx <= haddr_i[7:2];
        end
    end

    // Draw stalls only while the single output slot is still occupied
    assign hreadyout_o = !(dp_valid && dp_write && dp_idx == IDX_DRAW &&
                           tri_valid_o && !tri_ready_i);
    assign hresp_o = 1'b0;
    assign wr_fire = dp_valid && dp_write && hreadyout_o;
    assign do_begin = wr_fire && dp_idx == IDX_BEGIN;
    assign do_draw = wr_fire && dp_idx == IDX_DRAW;

    always_comb begin
        unique case (haddr_i[7:2])
            // Mode write in its data phase is forwarded to a back-to-back read
            IDX_MODE: rd_mux = (wr_fire && dp_idx == IDX_MODE) ?
                               (hwdata_i & MODE_WMASK) : setup_param_mode;
            IDX_COUNT, IDX_COUNT_ALIAS: rd_mux = {8'h00, triangle_count};
            IDX_STATUS: rd_mux = {28'h000_0000, parity, tri_valid_o, vcnt};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (addr_take && !hwrite_i) begin
            hrdata_o <= rd_mux;
        end
    end

    // Mode register
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            setup_param_mode <= MODE_RESET;
        end else if (wr_fire && dp_idx == IDX_MODE) begin
            setup_param_mode <= hwdata_i & MODE_WMASK;
        end
    end

    // Current-vertex parameter words
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur <= '0;
        end else if (wr_fire && is_field(dp_idx)) begin
            cur[4'(dp_idx - IDX_FIELD0)] <= hwdata_i;
        end
    end

    // Submitted vertex: selected fields new, others carried forward
    always_comb begin
        for (int i = 0; i < TSQ_NF; i++) begin
            next_vtx[i] = (cur[i] & field_en(setup_param_mode, i)) |
                          (held[i] & ~field_en(setup_param_mode, i));
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            held <= '0;
        end else if (do_begin || do_draw) begin
            held <= next_vtx;
        end
    end

    // Triangle formed on a draw once two vertices are held
    assign make_tri = do_draw && vcnt == 2'd2;

    tsq_cull_sign u_sign (
        .ax_i(slot0[F_X]),
        .ay_i(slot0[F_Y]),
        .bx_i(slot1[F_X]),
        .by_i(slot1[F_Y]),
        .cx_i(next_vtx[F_X]),
        .cy_i(next_vtx[F_Y]),
        .area_neg_o(area_neg)
    );

    // Alternate strip triangles have reversed winding
    assign neg_eff = area_neg ^ (parity && !setup_param_mode[MB_FAN] &&
                                 !setup_param_mode[MB_NO_PINGPONG]);
    assign cull = setup_param_mode[MB_CULL_EN] &&
                  (setup_param_mode[MB_CULL_NEG] ? neg_eff : !neg_eff);

    // Vertex slots: slot0 is strip oldest or fan pivot
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slot0 <= '0;
            slot1 <= '0;
            vcnt <= 2'd0;
        end else if (do_begin || (do_draw && vcnt == 2'd0)) begin
            slot0 <= next_vtx;
            vcnt <= 2'd1;
        end else if (do_draw && vcnt == 2'd1) begin
            slot1 <= next_vtx;
            vcnt <= 2'd2;
        end else if (make_tri) begin
            if (!setup_param_mode[MB_FAN]) begin
                slot0 <= slot1;
            end
            slot1 <= next_vtx;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            parity <= 1'b0;
        end else if (do_begin) begin
            parity <= 1'b0;
        end else if (make_tri) begin
            parity <= !parity;
        end
    end

    // Output slot toward the rasterizer
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tri_valid_o <= 1'b0;
        end else if (make_tri && !cull) begin
            tri_valid_o <= 1'b1;
        end else if (tri_ready_i) begin
            tri_valid_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tri_vtx0_o <= '0;
            tri_vtx1_o <= '0;
            tri_vtx2_o <= '0;
            tri_param_sel_o <= 8'h00;
            tri_neg_sign_o <= 1'b0;
            pbu_global_inv_w_o <= 32'h0000_0000;
            tex_global_inv_w_o <= 32'h0000_0000;
        end else if (make_tri && !cull) begin
            tri_vtx0_o <= slot0;
            tri_vtx1_o <= slot1;
            tri_vtx2_o <= next_vtx;
            tri_param_sel_o <= setup_param_mode[7:0];
            tri_neg_sign_o <= neg_eff;
            pbu_global_inv_w_o <= next_vtx[F_GINVW];
            tex_global_inv_w_o <= next_vtx[F_GINVW];
        end
    end

    // Triangle counter; an increment in the clearing cycle still counts
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            triangle_count <= COUNT_RESET;
        end else if (wr_fire && dp_idx == IDX_NOP && hwdata_i[NOP_CLR_TRI]) begin
            triangle_count <= COUNT_RESET + TSQ_CNT_W'(tri_valid_o && tri_ready_i);
        end else if (tri_valid_o && tri_ready_i) begin
            triangle_count <= triangle_count + 24'h00_0001;
        end
    end

endmodule

/* hw/tsq_pkg.sv */
package tsq_pkg;

    localparam int TSQ_NF = 11;
    localparam int TSQ_CNT_W = 24;

    // Vertex field slots
    localparam int F_X = 0;
    localparam int F_Y = 1;
    localparam int F_ARGB = 2;
    localparam int F_Z = 3;
    localparam int F_GINVW = 4;
    localparam int F_TEX0_INVW = 5;
    localparam int F_TEX0_S = 6;
    localparam int F_TEX0_T = 7;
    localparam int F_TEX1_INVW = 8;
    localparam int F_TEX1_S = 9;
    localparam int F_TEX1_T = 10;

    // Word indexes, byte address = index * 4
    localparam logic [5:0] IDX_MODE = 6'h00;
    localparam logic [5:0] IDX_FIELD0 = 6'h01;
    localparam logic [5:0] IDX_DRAW = 6'h0C;
    localparam logic [5:0] IDX_BEGIN = 6'h0D;
    localparam logic [5:0] IDX_NOP = 6'h0E;
    localparam logic [5:0] IDX_COUNT = 6'h0F;
    localparam logic [5:0] IDX_COUNT_ALIAS = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h11;

    // setup_param_mode fields
    localparam int MB_RGB = 0;
    localparam int MB_ALPHA = 1;
    localparam int MB_Z = 2;
    localparam int MB_GINVW = 3;
    localparam int MB_TEX0_INVW = 4;
    localparam int MB_ST0 = 5;
    localparam int MB_TEX1_INVW = 6;
    localparam int MB_ST1 = 7;
    localparam int MB_FAN = 16;
    localparam int MB_CULL_EN = 17;
    localparam int MB_CULL_NEG = 18;
    localparam int MB_NO_PINGPONG = 19;
    localparam logic [31:0] MODE_WMASK = 32'h000F_00FF;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam int NOP_CLR_TRI = 1;
    localparam logic [TSQ_CNT_W-1:0] COUNT_RESET = 24'h00_0000;

    // Float exponent that maps to 4 fraction bits of the fixed result
    localparam logic [7:0] FIX_EXP = 8'h92;

    // Float to signed fixed point with 4 fraction bits, saturating
    function automatic logic signed [23:0] tsq_f2fix(input logic [31:0] f);
        logic [47:0] mag;
        logic [7:0] sh;
        logic [22:0] lim;
        mag = {24'h00_0000, 1'b1, f[22:0]};
        sh = 8'h00;
        if (f[30:23] == 8'h00) begin
            mag = 48'h0000_0000_0000;
        end else if (f[30:23] >= FIX_EXP) begin
            sh = f[30:23] - FIX_EXP;
            mag = (sh > 8'h17) ? 48'hFFFF_FFFF_FFFF : (mag << sh);
        end else begin
            sh = FIX_EXP - f[30:23];
            mag = (sh > 8'h2F) ? 48'h0000_0000_0000 : (mag >> sh);
        end
        lim = (|mag[47:23]) ? 23'h7F_FFFF : mag[22:0];
        return f[31] ? -$signed({1'b0, lim}) : $signed({1'b0, lim});
    endfunction

endpackage

/* hw/tsq_cull_sign.sv */
module tsq_cull_sign (
    input wire logic [31:0] ax_i,
    input wire logic [31:0] ay_i,
    input wire logic [31:0] bx_i,
    input wire logic [31:0] by_i,
    input wire logic [31:0] cx_i,
    input wire logic [31:0] cy_i,
    output logic area_neg_o
);
    import tsq_pkg::*;

    logic signed [24:0] d1x;
    logic signed [24:0] d1y;
    logic signed [24:0] d2x;
    logic signed [24:0] d2y;
    logic signed [50:0] area;

    // Twice the signed area of a-b-c in fixed point
    always_comb begin
        d1x = 25'(tsq_f2fix(bx_i)) - 25'(tsq_f2fix(ax_i));
        d1y = 25'(tsq_f2fix(by_i)) - 25'(tsq_f2fix(ay_i));
        d2x = 25'(tsq_f2fix(cx_i)) - 25'(tsq_f2fix(ax_i));
        d2y = 25'(tsq_f2fix(cy_i)) - 25'(tsq_f2fix(ay_i));
        area = 51'(d1x * d2y) - 51'(d2x * d1y);
    end

    assign area_neg_o = area[50];

endmodule

/* dv/tsq_setup_seq_sva.sv */
module tsq_setup_seq_chk (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic tri_valid_o,
    input wire logic tri_ready_i,
    input wire logic [tsq_pkg::TSQ_NF-1:0][31:0] tri_vtx0_o,
    input wire logic [tsq_pkg::TSQ_NF-1:0][31:0] tri_vtx2_o,
    input wire logic [7:0] tri_param_sel_o,
    input wire logic [31:0] pbu_global_inv_w_o,
    input wire logic [31:0] tex_global_inv_w_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import tsq_pkg::*;
    logic draw_dph;

    // Marks the data phase of a draw command write
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            draw_dph <= 1'b0;
        end else if (hreadyout_o) begin
            draw_dph <= hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i[7:2] == IDX_DRAW;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    launch_after_draw_a: assert property ($rose(tri_valid_o) |-> $past(draw_dph && hreadyout_o))
        else $error("triangle offered without a completed draw");
    valid_hold_a: assert property (tri_valid_o && !tri_ready_i |=> tri_valid_o)
        else $error("triangle withdrawn before being taken");
    vertex_hold_a: assert property (tri_valid_o && !tri_ready_i |=> $stable(tri_vtx0_o) && $stable(tri_vtx2_o))
        else $error("vertex data changed while waiting");
    sel_hold_a: assert property (tri_valid_o && !tri_ready_i |=> $stable(tri_param_sel_o))
        else $error("parameter select changed while waiting");
    inv_w_share_a: assert property (tri_valid_o |->
        pbu_global_inv_w_o == tex_global_inv_w_o && pbu_global_inv_w_o == tri_vtx2_o[F_GINVW])
        else $error("global inverse w differs from the newest vertex");
    stall_when_full_a: assert property (!hreadyout_o |-> draw_dph && tri_valid_o && !tri_ready_i)
        else $error("bus stalled without a full slot");
    stall_release_a: assert property (draw_dph && tri_ready_i |-> hreadyout_o)
        else $error("draw not completed when slot frees");
    slot_free_a: assert property (tri_valid_o && tri_ready_i && !(draw_dph && hreadyout_o) |=> !tri_valid_o)
        else $error("taken triangle still offered");
endmodule

bind tsq_setup_seq tsq_setup_seq_chk i_chk (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .tri_valid_o(tri_valid_o),
    .tri_ready_i(tri_ready_i),
    .tri_vtx0_o(tri_vtx0_o),
    .tri_vtx2_o(tri_vtx2_o),
    .tri_param_sel_o(tri_param_sel_o),
    .pbu_global_inv_w_o(pbu_global_inv_w_o),
    .tex_global_inv_w_o(tex_global_inv_w_o)
);

/* dv/test_triangle_setup_sequencer.sv */
module test_triangle_setup_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import tsq_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic tri_ready_i = 1'b0;
    logic rd_ph = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_002E;
    logic [31:0] rseed = 32'h0000_002E;
    logic [31:0] hc = 32'h0000_0000;
    logic [31:0] gw = 32'h0000_0000;
    logic [7:0] psel;
    logic [31:0] gw_p;
    logic [31:0] gw_t;
    logic [255:0] tri_seen;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic tri_valid_o;
    logic tri_neg_sign_o;
    logic [TSQ_NF-1:0][31:0] v0, v1, v2;
    logic [31:0] rq[$];
    logic [255:0] tq[$];
    logic [31:0] modes[6] = '{32'h0000_0003, 32'h0008_0001, 32'h0001_0002,
                              32'h0002_0003, 32'h0006_0003, 32'h0007_000B};
    int mismatches = 0;
    int num_checks = 0;
    int total = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    tsq_setup_seq i_dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(),
        .tri_valid_o(tri_valid_o), .tri_ready_i(tri_ready_i), .tri_vtx0_o(v0),
        .tri_vtx1_o(v1), .tri_vtx2_o(v2), .tri_param_sel_o(psel),
        .tri_neg_sign_o(tri_neg_sign_o),
        .pbu_global_inv_w_o(gw_p), .tex_global_inv_w_o(gw_t)
    );

    assign tri_seen = 256'({tri_neg_sign_o, psel, v0[F_X], v1[F_X], v2[F_X], v2[F_ARGB],
                            gw_p, gw_t});

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
        @(posedge ref_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        haddr_i <= {24'h00_0000, idx, 2'h0};
        do @(posedge ref_clk_i); while (!hreadyout_o);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        rd_ph <= !wr;
        do @(posedge ref_clk_i); while (!hreadyout_o);
        rd_ph <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        rq.push_back(exp);
        bus(1'b0, idx, 32'h0000_0000);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Five collinear vertices: zero area, so only strip alternation sets the sign
    task automatic run_seq(input logic [31:0] m);
        logic [31:0] x[5];
        logic [31:0] c;
        logic neg;
        bus(1'b1, IDX_MODE, m | 32'hFFF0_FF00);
        rd(IDX_MODE, m);
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            x[i] = seed;
            seed = xs(seed);
            c = seed;
            bus(1'b1, IDX_FIELD0, x[i]);
            bus(1'b1, IDX_FIELD0 + 6'h01, 32'h0000_0000);
            bus(1'b1, IDX_FIELD0 + 6'h02, c);
            seed = xs(seed);
            bus(1'b1, IDX_FIELD0 + 6'(F_GINVW), seed);
            gw = m[3] ? seed : gw;
            hc = {m[1] ? c[31:24] : hc[31:24], m[0] ? c[23:0] : hc[23:0]};
            neg = !m[16] && !m[19] && i[0];
            if (i >= 2 && !(m[17] && neg == m[18])) begin
                tq.push_back(256'({neg, m[7:0], m[16] ? x[0] : x[i-2], x[i-1], x[i],
                                   hc, gw, gw}));
                total++;
            end
            bus(1'b1, i == 0 ? IDX_BEGIN : IDX_DRAW, 32'h0000_0001);
        end
        do @(posedge ref_clk_i); while (tri_valid_o);
        rd(IDX_COUNT, 32'(total));
        rd(IDX_COUNT_ALIAS, 32'(total));
        rd(IDX_STATUS, 32'h0000_000A);
    endtask

    always @(posedge ref_clk_i) begin
        if (rd_ph && hreadyout_o) begin
            check(256'(hrdata_o), 256'(rq.pop_front()));
        end
        if (tri_valid_o && tri_ready_i) begin
            check(tri_seen, tq.pop_front());
        end
        rseed = xs(rseed);
        tri_ready_i <= rseed[4];
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        end_of_test;
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rd(IDX_MODE, MODE_RESET);
        rd(IDX_COUNT, 32'h0000_0000);
        rd(6'h3F, 32'h0000_0000);
        foreach (modes[k]) begin
            run_seq(modes[k]);
            $display("test %0d done", k);
        end
        bus(1'b1, IDX_NOP, 32'h0000_0001);
        rd(IDX_COUNT, 32'(total));
        bus(1'b1, IDX_NOP, 32'h0000_0002);
        rd(IDX_COUNT, 32'h0000_0000);
        $display("test counter clear done");
        repeat (2) @(posedge ref_clk_i);
        end_of_test;
    end
endmodule
